// file: logic/wake_status_pkg.sv
// Constants shared by the wake status latch bank
package wake_status_pkg;
    // ------------------------------------------------------------
    // Register word offsets (byte addresses, word aligned)
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] IDX_STATUS_ONE = 8'hb2;
    localparam logic [7:0] IDX_STATUS_TWO = 8'hb3;
    localparam logic [9:0] OFF_STATUS_ONE = 10'h2c8;
    localparam logic [9:0] OFF_STATUS_TWO = 10'h2cc;
    localparam logic [9:0] OFF_ENABLE_ONE = 10'h2c0;
    localparam logic [9:0] OFF_ENABLE_TWO = 10'h2c4;
    localparam logic [9:0] OFF_IRQ_STATUS = 10'h300;
    localparam logic [9:0] OFF_IRQ_MASK = 10'h304;
    // ------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] RST_STATUS = 8'h00;
    localparam logic [7:0] RST_ENABLE_ONE = 8'h00;
    localparam logic [7:0] RST_ENABLE_TWO = 8'h80;
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [7:0] ONE_LATCH_MASK = 8'hcf;
    localparam logic [7:0] TWO_LIVE_MASK = 8'h2b;
    localparam logic [7:0] TWO_WAKE_MASK = 8'h2b;
    localparam logic [7:0] TWO_LATCH_MASK = 8'h2f;
    localparam logic [7:0] EN_TWO_WR_MASK = 8'hab;
    localparam logic [7:0] IRQ_BITS_MASK = 8'h07;
    localparam int BIT_IRQ_ONE = 0;
    localparam int BIT_IRQ_TWO = 1;
    localparam int BIT_IRQ_POWER = 2;
endpackage

// file: logic/fall_edge_sync.sv
// Two-flop synchroniser with falling edge detect for one pin
`timescale 1ns/1ps
module fall_edge_sync
    import wake_status_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic pin_in,
    output logic fall_out
);
    logic meta_q;
    logic sync_q;
    logic last_q;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            last_q <= 1'b1;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end
    assign fall_out = last_q & ~sync_q;
endmodule

// file: logic/wake_event_status_latches.sv
// Wake event status latches with Avalon-MM register slave
`timescale 1ns/1ps
module wake_event_status_latches
    import wake_status_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [9:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic [1:0] avs_response_out,
    input wire logic port_one_ring_n_in,
    input wire logic port_two_ring_n_in,
    input wire logic kbd_clock_in,
    input wire logic mouse_clock_in,
    input wire logic infrared_rx_b_in,
    input wire logic port_one_rx_in,
    input wire logic port_two_rx_in,
    input wire logic ring_input_n_in,
    input wire logic button_n_in,
    input wire logic alarm_in,
    input wire logic group_irq_a_in,
    input wire logic group_irq_b_in,
    input wire logic remote_ir_wake_in,
    output logic power_on_request_n_out,
    output logic irq_out
);
    // ------------------------------------------------------------
    // Pin edge detection
    // ------------------------------------------------------------
    localparam int NPIN = 9;
    logic [NPIN-1:0] pins;
    logic [NPIN-1:0] falls;
    assign pins = {button_n_in, ring_input_n_in, port_two_rx_in,
                   port_one_rx_in, infrared_rx_b_in, mouse_clock_in,
                   kbd_clock_in, port_two_ring_n_in, port_one_ring_n_in};
    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_pin
            fall_edge_sync u_sync (
                .clk_in(clk_in),
                .rst_n_in(rst_n_in),
                .pin_in(pins[g]),
                .fall_out(falls[g])
            );
        end
    endgenerate

    // Internal level sources pass two flops as well
    logic [3:0] lvl_meta_q;
    logic [3:0] lvl_sync_q;
    logic [3:0] lvl_last_q;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            lvl_meta_q <= 4'h0;
            lvl_sync_q <= 4'h0;
            lvl_last_q <= 4'h0;
        end else begin
            lvl_meta_q <= {remote_ir_wake_in, group_irq_b_in,
                           group_irq_a_in, alarm_in};
            lvl_sync_q <= lvl_meta_q;
            lvl_last_q <= lvl_sync_q;
        end
    end
    logic alarm_rise;
    logic remote_rise;
    assign alarm_rise = lvl_sync_q[0] & ~lvl_last_q[0];
    assign remote_rise = lvl_sync_q[3] & ~lvl_last_q[3];

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic ack_q;
    logic [31:0] rdata_q;
    logic [1:0] resp_q;
    logic req;
    logic take;
    assign req = avs_read_in | avs_write_in;
    assign take = req & ~ack_q;
    logic sel_one;
    logic sel_two;
    logic sel_en1;
    logic sel_en2;
    logic sel_ist;
    logic sel_msk;
    logic mapped;
    // Address match of one register word
    function automatic logic addr_hit(logic [9:0] a, logic [9:0] off);
        return a == off;
    endfunction
    assign sel_one = addr_hit(avs_address_in, OFF_STATUS_ONE);
    assign sel_two = addr_hit(avs_address_in, OFF_STATUS_TWO);
    assign sel_en1 = addr_hit(avs_address_in, OFF_ENABLE_ONE);
    assign sel_en2 = addr_hit(avs_address_in, OFF_ENABLE_TWO);
    assign sel_ist = addr_hit(avs_address_in, OFF_IRQ_STATUS);
    assign sel_msk = addr_hit(avs_address_in, OFF_IRQ_MASK);
    assign mapped = sel_one | sel_two | sel_en1 | sel_en2 | sel_ist
                  | sel_msk;
    logic wr_lane0;
    assign wr_lane0 = take & avs_write_in & avs_byteenable_in[0];
    logic rd_one;
    logic rd_two;
    assign rd_one = take & avs_read_in & sel_one;
    assign rd_two = take & avs_read_in & sel_two;

    // ------------------------------------------------------------
    // Status latches
    // ------------------------------------------------------------
    logic [7:0] one_q;
    logic [7:0] one_d;
    logic [7:0] two_q;
    logic [7:0] two_d;
    logic [7:0] one_set;
    logic [7:0] two_set;
    assign one_set = {alarm_rise, falls[4], 2'b00,
                      falls[3], falls[2], falls[1], falls[0]};
    assign two_set = {2'b00, remote_rise, 1'b0, falls[7], falls[8],
                      falls[6], falls[5]};
    assign one_d = ((rd_one ? 8'h00 : one_q) | one_set) & ONE_LATCH_MASK;
    assign two_d = ((rd_two ? 8'h00 : two_q) | two_set) & TWO_LATCH_MASK;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            one_q <= RST_STATUS;
            two_q <= RST_STATUS;
        end else begin
            one_q <= one_d;
            two_q <= two_d;
        end
    end
    logic [7:0] one_view;
    assign one_view = one_q | {2'b00, lvl_sync_q[2], lvl_sync_q[1], 4'h0};

    // ------------------------------------------------------------
    // Enables and power on request
    // ------------------------------------------------------------
    logic [7:0] en1_q;
    logic [7:0] en2_q;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            en1_q <= RST_ENABLE_ONE;
            en2_q <= RST_ENABLE_TWO;
        end else begin
            if (wr_lane0 && sel_en1) begin
                en1_q <= avs_writedata_in[7:0];
            end
            if (wr_lane0 && sel_en2) begin
                en2_q <= avs_writedata_in[7:0] & EN_TWO_WR_MASK;
            end
        end
    end
    logic wake;
    assign wake = |(one_view & en1_q) | |(two_q & en2_q & TWO_WAKE_MASK);
    logic pwr_n_q;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            pwr_n_q <= 1'b1;
        end else begin
            pwr_n_q <= ~wake;
        end
    end

    // ------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------
    logic [7:0] ist_q;
    logic [7:0] msk_q;
    logic [7:0] ist_set;
    logic [7:0] ist_clr;
    logic irq_q;
    assign ist_set = {5'h00, wake & pwr_n_q, |two_set, |one_set};
    assign ist_clr = (wr_lane0 & sel_ist) ? avs_writedata_in[7:0] : 8'h00;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ist_q <= RST_STATUS;
            msk_q <= RST_MASK;
            irq_q <= 1'b0;
        end else begin
            ist_q <= ((ist_q & ~ist_clr) | ist_set) & IRQ_BITS_MASK;
            if (wr_lane0 && sel_msk) begin
                msk_q <= avs_writedata_in[7:0] & IRQ_BITS_MASK;
            end
            irq_q <= |(ist_q & msk_q);
        end
    end

    // ------------------------------------------------------------
    // Read mux and answer
    // ------------------------------------------------------------
    logic [7:0] rmux;
    assign rmux = sel_one ? one_view :
                  sel_two ? two_q :
                  sel_en1 ? en1_q :
                  sel_en2 ? en2_q :
                  sel_ist ? ist_q :
                  sel_msk ? msk_q : 8'h00;
    logic wait_q;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= ~take;
        end
    end
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            resp_q <= 2'h0;
        end else begin
            ack_q <= take;
            if (take) begin
                rdata_q <= avs_read_in ? {24'h000000, rmux} : 32'h0000_0000;
                resp_q <= mapped ? 2'h0 : 2'h2;
            end
        end
    end
    assign avs_waitrequest_out = wait_q;
    assign avs_readdata_out = rdata_q;
    assign avs_response_out = resp_q;
    assign power_on_request_n_out = pwr_n_q;
    assign irq_out = irq_q;
endmodule

// file: verification/wake_status_checker.sv
// Checker for bus handshake and status read timing
`timescale 1ns/1ps
module wake_status_checker
    import wake_status_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [9:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic [1:0] avs_response_out,
    input wire logic group_irq_a_in,
    input wire logic group_irq_b_in,
    input wire logic power_on_request_n_out,
    input wire logic irq_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    wire req = avs_read_in | avs_write_in;
    wire take = req & avs_waitrequest_out;
    wire mapped = avs_address_in inside {OFF_STATUS_ONE, OFF_STATUS_TWO,
        OFF_ENABLE_ONE, OFF_ENABLE_TWO, OFF_IRQ_STATUS, OFF_IRQ_MASK};
    wire rd_one = take & avs_read_in & (avs_address_in == OFF_STATUS_ONE);
    a_take_answers: assert property (take |=> !avs_waitrequest_out)
        else $error("no answer one cycle after request");
    a_wait_pulse: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low too long");
    a_idle_waits: assert property (!req |=> avs_waitrequest_out)
        else $error("answer without request");
    a_unmapped_err: assert property (take && !mapped |=>
        avs_response_out == 2'b10 && avs_readdata_out == 32'h0)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (take && mapped |=> avs_response_out == 2'b00)
        else $error("mapped access refused");
    a_upper_zero: assert property (!avs_waitrequest_out |->
        avs_readdata_out[31:8] == 24'h0) else $error("upper read bits set");
    a_group_a_live: assert property (group_irq_a_in[*6] ##0 rd_one |=>
        avs_readdata_out[4]) else $error("group a not shown");
    a_group_b_live: assert property ((!group_irq_b_in)[*6] ##0 rd_one |=>
        !avs_readdata_out[5]) else $error("group b shown while low");
    a_reset_quiet: assert property ($rose(rst_n_in) |-> avs_waitrequest_out &&
        !irq_out && power_on_request_n_out) else $error("outputs active at reset");
    cover property (rd_one);
    cover property (!power_on_request_n_out);
    cover property (irq_out);
endmodule
bind wake_event_status_latches wake_status_checker i_wake_status_checker (.*);

// file: verification/wake_event_status_latches_bench.sv
// Self-checking bench for the wake status latches
`timescale 1ns/1ps
module wake_event_status_latches_bench
    import wake_status_pkg::*;
;
    logic clk_in = 0, rst_n_in = 0, rd = 0, wr = 0, wreq, pwr_n, irq;
    logic alarm = 0, remote = 0, ga = 0, gb = 0;
    logic [9:0] addr = 0;
    logic [31:0] wdata = 0, rdata, got, g1;
    logic [1:0] resp;
    logic [8:0] pins = '1, m;
    int errors = 0, samples_checked = 0, cycles = 0, seed = 32'h44b3;
    wake_event_status_latches i_wake_event_status_latches (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_byteenable_in(4'hf), .avs_readdata_out(rdata),
        .avs_waitrequest_out(wreq), .avs_response_out(resp),
        .port_one_ring_n_in(pins[0]), .port_two_ring_n_in(pins[1]),
        .kbd_clock_in(pins[2]), .mouse_clock_in(pins[3]),
        .infrared_rx_b_in(pins[4]), .port_one_rx_in(pins[5]),
        .port_two_rx_in(pins[6]), .ring_input_n_in(pins[7]),
        .button_n_in(pins[8]), .alarm_in(alarm), .group_irq_a_in(ga),
        .group_irq_b_in(gb), .remote_ir_wake_in(remote),
        .power_on_request_n_out(pwr_n), .irq_out(irq));
    initial forever #20 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            complete_run();
        end
    end
    // ------------------------------------------------------------
    // Tasks and expectations
    // ------------------------------------------------------------
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic bus(logic w, logic [9:0] a, logic [31:0] d);
        @(posedge clk_in);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        do @(posedge clk_in); while (wreq !== 1'b0);
        got = rdata;
        rd <= 0;
        wr <= 0;
    endtask
    task automatic rd_both(logic [15:0] e);
        bus(0, OFF_STATUS_ONE, 0);
        check("status one", got, {24'h0, e[7:0]});
        bus(0, OFF_STATUS_TWO, 0);
        check("status two", got, {24'h0, e[15:8]});
    endtask
    task automatic hold(logic [8:0] f);
        pins <= ~f;
        tick(6);
    endtask
    task automatic fall(logic [8:0] f);
        hold(f);
        pins <= '1;
        tick(6);
    endtask
    function automatic logic [15:0] expect_status(logic [8:0] f);
        return {4'h0, f[7], f[8], f[6:5], 1'b0, f[4], 2'b00, f[3:0]};
    endfunction
    task automatic complete_run();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        tick(3);
        rst_n_in <= 1;
        rd_both(16'h0);
        bus(0, OFF_ENABLE_TWO, 0);
        check("enable two", got, 32'h80);
        bus(0, 10'h3f0, 0);
        check("unmapped resp", resp, 2'b10);
        $display("test reset done");
        for (int i = 0; i < 9; i++) begin
            fall(9'h1 << i);
            rd_both(expect_status(9'h1 << i));
            rd_both(16'h0);
        end
        $display("test single pins done");
        for (int k = 0; k < 22; k++) begin
            m = (k == 0) ? 9'h1ff : (k == 1) ? 9'h0 : 9'($random(seed));
            fall(m);
            rd_both(expect_status(m));
        end
        $display("test random pins done");
        alarm <= 1;
        tick(6);
        alarm <= 0;
        remote <= 1;
        tick(6);
        remote <= 0;
        rd_both(16'h2080);
        ga <= 1;
        tick(8);
        rd_both(16'h0010);
        rd_both(16'h0010);
        ga <= 0;
        gb <= 1;
        tick(8);
        rd_both(16'h0020);
        gb <= 0;
        tick(8);
        $display("test alarm and group done");
        for (int k = 0; k < 6; k++) begin
            pins <= ~9'h4;
            tick(k);
            bus(0, OFF_STATUS_ONE, 0);
            g1 = got;
            pins <= '1;
            tick(6);
            bus(0, OFF_STATUS_ONE, 0);
            check("read race", (g1 | got) & 32'h4, 32'h4);
        end
        $display("test read race done");
        bus(1, OFF_IRQ_STATUS, 32'h7);
        bus(1, OFF_IRQ_MASK, 32'h1);
        tick(3);
        check("irq idle", irq, 1'b0);
        fall(9'h1);
        rd_both(16'h1);
        check("irq sticky", irq, 1'b1);
        bus(1, OFF_IRQ_STATUS, 32'h1);
        tick(3);
        check("irq cleared", irq, 1'b0);
        bus(1, OFF_IRQ_MASK, 32'h0);
        fall(9'h2);
        check("irq masked", irq, 1'b0);
        $display("test irq done");
        hold(9'h180);
        check("power off", pwr_n, 1'b1);
        pins <= '1;
        bus(1, OFF_ENABLE_TWO, 32'ha8);
        bus(0, OFF_ENABLE_TWO, 0);
        check("enable two", got, 32'ha8);
        hold(9'h080);
        check("power ring", pwr_n, 1'b0);
        pins <= '1;
        bus(0, OFF_STATUS_TWO, 0);
        check("ring status", got, 32'h0c);
        tick(3);
        check("power released", pwr_n, 1'b1);
        remote <= 1;
        tick(6);
        check("power remote", pwr_n, 1'b0);
        $display("test power done");
        complete_run();
    end
endmodule
